/* verilog/i2csd_regs.sv */
// Status, clock divider and own target address registers of the two-wire bus controller
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none

module i2csd_regs
  import i2csd_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [i2csd_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire i2csd_pkg::i2csd_buf_t    buf_state,
  input  wire i2csd_pkg::i2csd_act_t    act_request,
  input  wire i2csd_pkg::i2csd_act_t    act_done,
  output i2csd_pkg::i2csd_status_t      status,
  output logic      [8:0]               clk_div,
  output logic      [6:0]               own_addr,
  output logic                          scl_tick,
  output logic                          irq
);
  import i2csd_pkg::*;

  // ==========================================================
  // Address decode
  function automatic i2csd_sel_t decode(input logic [ADDR_W-1:0] a);
    if (a == OFF_STATUS) begin
      return SEL_STATUS;
    end else if (a == OFF_CLKDIV) begin
      return SEL_CLKDIV;
    end else if (a == OFF_SADDR) begin
      return SEL_SADDR;
    end else if (a == OFF_IRQ_FLAG) begin
      return SEL_FLAG;
    end else if (a == OFF_IRQ_MASK) begin
      return SEL_MASK;
    end else begin
      return SEL_NONE;
    end
  endfunction : decode

  i2csd_state_t st;
  i2csd_state_t next_st;
  i2csd_sel_t   sel;
  logic         setup;
  logic         access;
  logic         wr;
  i2csd_irq_t   ev;

  assign sel    = decode(paddr);
  assign setup  = psel && !penable;
  assign access = psel && penable && st.pready;
  assign wr     = access && pwrite;

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;

    // Buffer levels follow the core
    next_st.status.rx_byte_waiting  = buf_state.rx_not_empty;
    next_st.status.tx_holding_empty = buf_state.tx_empty;

    // Set wins over clear
    if (buf_state.tx_end && buf_state.tx_empty) begin
      next_st.status.tx_finished = 1'b1;
    end else if (buf_state.tx_begin) begin
      next_st.status.tx_finished = 1'b0;
    end

    // Queued actions: request sets, completion clears, request wins
    next_st.status.queued = (st.status.queued & ~act_done) | act_request;

    // Rising edges raise interrupt events
    ev.rx_ev       = next_st.status.rx_byte_waiting  && !st.status.rx_byte_waiting;
    ev.tx_fin_ev   = next_st.status.tx_finished      && !st.status.tx_finished;
    ev.tx_empty_ev = next_st.status.tx_holding_empty && !st.status.tx_holding_empty;

    // APB answer one cycle after setup
    next_st.pready  = setup;
    next_st.pslverr = setup && (sel == SEL_NONE);
    if (setup && !pwrite) begin
      if (sel == SEL_STATUS) begin
        next_st.prdata = {{(32 - STATUS_W){1'b0}}, st.status};
      end else if (sel == SEL_CLKDIV) begin
        next_st.prdata = {{(32 - DIV_W){1'b0}}, st.div};
      end else if (sel == SEL_SADDR) begin
        next_st.prdata = {24'h000000, st.saddr, 1'b0};
      end else if (sel == SEL_FLAG) begin
        next_st.prdata = {{(32 - IRQ_W){1'b0}}, st.flag};
      end else if (sel == SEL_MASK) begin
        next_st.prdata = {{(32 - IRQ_W){1'b0}}, st.mask};
      end else begin
        next_st.prdata = 32'h00000000;
      end
    end else if (setup) begin
      next_st.prdata = 32'h00000000;
    end

    // Register writes; status writes fall through unused
    next_st.flag = st.flag;
    if (wr && sel == SEL_CLKDIV) begin
      next_st.div = pwdata[DIV_W-1:0];
    end else if (wr && sel == SEL_SADDR) begin
      next_st.saddr = pwdata[SADDR_LSB +: SADDR_W];
    end else if (wr && sel == SEL_FLAG) begin
      next_st.flag = st.flag & ~i2csd_irq_t'(pwdata[IRQ_W-1:0]);
    end else if (wr && sel == SEL_MASK) begin
      next_st.mask = i2csd_irq_t'(pwdata[IRQ_W-1:0]);
    end
    next_st.flag = next_st.flag | ev;
    next_st.irq  = |(next_st.flag & next_st.mask);

    // Serial rate tick, every div+1 cycles
    if (st.tick_cnt >= st.div) begin
      next_st.tick_cnt = 9'h000;
      next_st.tick     = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 9'h001;
      next_st.tick     = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st                         <= '0;
      st.status.tx_holding_empty <= TX_EMPTY_RST;
      st.div                     <= DIV_RST;
      st.saddr                   <= SADDR_RST;
      st.flag                    <= IRQ_RST;
      st.mask                    <= IRQ_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata   = st.prdata;
  assign pready   = st.pready;
  assign pslverr  = st.pslverr;
  assign status   = st.status;
  assign clk_div  = st.div;
  assign own_addr = st.saddr;
  assign scl_tick = st.tick;
  assign irq      = st.irq;

  // ==========================================================
  // Checks
  property p_rx_wait;
    @(posedge pclk) disable iff (!presetn)
      buf_state.rx_not_empty |=> status.rx_byte_waiting;
  endproperty
  a_rx_wait: assert property (p_rx_wait) else $error("rx waiting bit missed data");

  property p_rx_clear;
    @(posedge pclk) disable iff (!presetn)
      !buf_state.rx_not_empty |=> !status.rx_byte_waiting;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx waiting bit stuck");

  property p_tx_empty;
    @(posedge pclk) disable iff (!presetn)
      ##1 status.tx_holding_empty == $past(buf_state.tx_empty);
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty bit wrong");

  property p_tx_fin_set;
    @(posedge pclk) disable iff (!presetn)
      (buf_state.tx_end && buf_state.tx_empty) |=> status.tx_finished;
  endproperty
  a_tx_fin_set: assert property (p_tx_fin_set) else $error("tx finished not set");

  property p_tx_fin_clr;
    @(posedge pclk) disable iff (!presetn)
      (buf_state.tx_begin && !(buf_state.tx_end && buf_state.tx_empty))
        |=> !status.tx_finished;
  endproperty
  a_tx_fin_clr: assert property (p_tx_fin_clr) else $error("tx finished not cleared");

  property p_start_stop;
    @(posedge pclk) disable iff (!presetn)
      (act_request.start_queued || act_request.stop_queued)
        |=> (status.queued.start_queued || !$past(act_request.start_queued))
         && (status.queued.stop_queued || !$past(act_request.stop_queued));
  endproperty
  a_start_stop: assert property (p_start_stop) else $error("start/stop not queued");

  property p_ack_hold;
    @(posedge pclk) disable iff (!presetn)
      (status.queued.ack_queued && !act_done.ack_queued) |=> status.queued.ack_queued;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped while queued");

  property p_nack_done;
    @(posedge pclk) disable iff (!presetn)
      (act_done.nack_queued && !act_request.nack_queued) |=> !status.queued.nack_queued;
  endproperty
  a_nack_done: assert property (p_nack_done) else $error("nack kept after done");

  property p_abort;
    @(posedge pclk) disable iff (!presetn)
      act_request.abort_queued |=> status.queued.abort_queued;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not queued");

  property p_cont;
    @(posedge pclk) disable iff (!presetn)
      (!act_request.continue_queued && !status.queued.continue_queued)
        |=> !status.queued.continue_queued;
  endproperty
  a_cont: assert property (p_cont) else $error("continue raised from nothing");

  property p_div_write;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && paddr == OFF_CLKDIV)
        |=> clk_div == $past(pwdata[8:0]);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divider write lost");

  property p_tick_zero;
    @(posedge pclk) disable iff (!presetn)
      (clk_div == 9'h000) [*2] |=> scl_tick;
  endproperty
  a_tick_zero: assert property (p_tick_zero) else $error("tick missing at divider zero");

  property p_addr_write;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && paddr == OFF_SADDR)
        |=> own_addr == $past(pwdata[7:1]);
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("address write lost");

  property p_status_ro;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && paddr == OFF_STATUS)
        |=> $stable(clk_div) && $stable(own_addr);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write had effect");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer timing wrong");

endmodule : i2csd_regs

`default_nettype wire

/* shared/i2csd_pkg.sv */
// Register map, field layout and carrier types of the status, divider and address block
package i2csd_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam int unsigned      ADDR_W        = 12;
  localparam logic [11:0]      OFF_STATUS    = 12'h00C;
  localparam logic [11:0]      OFF_CLKDIV    = 12'h010;
  localparam logic [11:0]      OFF_SADDR     = 12'h014;
  localparam logic [11:0]      OFF_IRQ_FLAG  = 12'h040;
  localparam logic [11:0]      OFF_IRQ_MASK  = 12'h044;

  // ==========================================================
  // Field positions and widths
  localparam int unsigned      STATUS_W      = 9;
  localparam int unsigned      DIV_W         = 9;
  localparam int unsigned      SADDR_LSB     = 1;
  localparam int unsigned      SADDR_W       = 7;
  localparam int unsigned      IRQ_W         = 3;
  localparam int unsigned      BIT_RX_WAIT   = 8;
  localparam int unsigned      BIT_TX_EMPTY  = 7;
  localparam int unsigned      BIT_TX_FIN    = 6;

  // ==========================================================
  // Reset values
  localparam logic [8:0]       DIV_RST       = 9'h000;
  localparam logic [6:0]       SADDR_RST     = 7'h00;
  localparam logic             TX_EMPTY_RST  = 1'h1;
  localparam logic [2:0]       IRQ_RST       = 3'h0;

  // ==========================================================
  // Carrier types
  // Queued bus actions, ordered as status bits 5..0
  typedef struct packed {
    logic abort_queued;
    logic continue_queued;
    logic nack_queued;
    logic ack_queued;
    logic stop_queued;
    logic start_queued;
  } i2csd_act_t;

  // Status word bits 8..0
  typedef struct packed {
    logic       rx_byte_waiting;
    logic       tx_holding_empty;
    logic       tx_finished;
    i2csd_act_t queued;
  } i2csd_status_t;

  // Buffer levels and transmission events from the controller core
  typedef struct packed {
    logic rx_not_empty;
    logic tx_empty;
    logic tx_begin;
    logic tx_end;
  } i2csd_buf_t;

  // Interrupt flag and mask layout
  typedef struct packed {
    logic tx_empty_ev;
    logic tx_fin_ev;
    logic rx_ev;
  } i2csd_irq_t;

  typedef enum {SEL_NONE, SEL_STATUS, SEL_CLKDIV, SEL_SADDR, SEL_FLAG, SEL_MASK} i2csd_sel_t;

  // Whole state of the block
  typedef struct packed {
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    i2csd_status_t status;
    logic [8:0]    div;
    logic [6:0]    saddr;
    i2csd_irq_t    flag;
    i2csd_irq_t    mask;
    logic          irq;
    logic [8:0]    tick_cnt;
    logic          tick;
  } i2csd_state_t;

endpackage : i2csd_pkg

/* verif/i2csd_core_model.sv */
// Far-side model of the controller core: buffer levels and queued bus actions
`timescale 1ns/10ps
`default_nettype none

module i2csd_core_model
  import i2csd_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [3:0]       ctl,
  input  wire logic [5:0]       act_in,
  output i2csd_pkg::i2csd_buf_t buf_state,
  output i2csd_pkg::i2csd_act_t act_request,
  output i2csd_pkg::i2csd_act_t act_done
);
  import i2csd_pkg::*;
  logic [1:0] rx_cnt;
  logic [1:0] tx_cnt;
  logic       tx_begin;
  logic       tx_end;
  logic [5:0] pend;
  logic [4:0] wait_cnt;

  assign buf_state = '{rx_not_empty: rx_cnt != 2'h0, tx_empty: tx_cnt == 2'h0,
                       tx_begin: tx_begin, tx_end: tx_end};

  // ==========================================================
  // Buffers: ctl = {rx_push, rx_pop, tx_load, tx_send}
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt <= 2'h0;
      tx_cnt <= 2'h0;
      tx_begin <= 1'b0;
      tx_end <= 1'b0;
    end else begin
      rx_cnt <= rx_cnt + 2'(ctl[3]) - 2'(ctl[2]);
      tx_cnt <= tx_cnt + 2'(ctl[1]) - 2'(ctl[0]);
      tx_begin <= ctl[0];
      tx_end <= tx_begin;
    end
  end

  // ==========================================================
  // Actions are carried out slowly, 21 cycles after queueing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 6'h00;
      wait_cnt <= 5'h00;
      act_request <= '0;
      act_done <= '0;
    end else begin
      act_request <= act_in;
      act_done <= '0;
      wait_cnt <= (pend != 6'h00) ? wait_cnt + 5'h01 : 5'h00;
      pend <= pend | act_in;
      if (wait_cnt == 5'h14) begin
        act_done <= pend;
        pend <= act_in;
        wait_cnt <= 5'h00;
      end
    end
  end
endmodule : i2csd_core_model

`default_nettype wire

/* verif/i2csd_regs_bench.sv */
// Self-checking bench of the status, divider and address registers
`timescale 1ns/10ps
`default_nettype none

module i2csd_regs_bench;
  import i2csd_pkg::*;
  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [11:0]   paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [3:0]    ctl;
  logic [5:0]    act_in;
  i2csd_buf_t    buf_state;
  i2csd_act_t    act_request;
  i2csd_act_t    act_done;
  i2csd_status_t status;
  logic [8:0]    clk_div;
  logic [6:0]    own_addr;
  logic          scl_tick;
  logic          irq;
  logic [31:0]   q;
  logic          e;
  int            n_mismatch;
  int            checked;
  int            cyc;

  i2csd_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .buf_state(buf_state), .act_request(act_request),
    .act_done(act_done), .status(status), .clk_div(clk_div), .own_addr(own_addr),
    .scl_tick(scl_tick), .irq(irq));
  i2csd_core_model core_u (.pclk(pclk), .presetn(presetn), .ctl(ctl), .act_in(act_in),
    .buf_state(buf_state), .act_request(act_request), .act_done(act_done));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic pulse(input logic [3:0] m);
    ctl <= m;
    @(posedge pclk);
    ctl <= 4'h0;
    repeat (4) @(posedge pclk);
  endtask : pulse

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    apb(1'b0, OFF_STATUS, 32'h0); chk(q, 32'h0000_0080);
    apb(1'b0, OFF_CLKDIV, 32'h0); chk(q, 32'h0000_0000);
    apb(1'b0, OFF_SADDR, 32'h0); chk(q, 32'h0000_0000);
  endtask : t_reset

  task automatic t_regs();
    apb(1'b1, OFF_CLKDIV, 32'h0000_01FF);
    apb(1'b0, OFF_CLKDIV, 32'h0); chk(q, 32'h0000_01FF);
    apb(1'b1, OFF_SADDR, 32'h0000_00FE);
    apb(1'b0, OFF_SADDR, 32'h0); chk(q, 32'h0000_00FE);
    chk({25'h0, own_addr}, 32'h0000_007F);
    apb(1'b1, OFF_STATUS, 32'h0000_01FF);
    apb(1'b0, OFF_STATUS, 32'h0); chk(q, 32'h0000_0080);
    apb(1'b0, 12'h030, 32'h0); chk({31'h0, e}, 32'h1);
  endtask : t_regs

  task automatic t_rst_mid();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
  endtask : t_rst_mid

  task automatic t_tick();
    int n;
    apb(1'b1, OFF_CLKDIV, 32'h0000_0003);
    chk({23'h0, clk_div}, 32'h0000_0003);
    while (scl_tick !== 1'b1) begin
      @(posedge pclk);
    end
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (scl_tick !== 1'b1);
    chk(n, 32'h0000_0004);
  endtask : t_tick

  task automatic t_rx();
    apb(1'b1, OFF_IRQ_MASK, 32'h7);
    pulse(4'h8);
    apb(1'b0, OFF_STATUS, 32'h0); chk(q, 32'h0000_0180);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFF_IRQ_FLAG, 32'h7);
    chk({31'h0, irq}, 32'h0);
    pulse(4'h4);
    apb(1'b0, OFF_STATUS, 32'h0); chk(q, 32'h0000_0080);
  endtask : t_rx

  task automatic t_act();
    for (int i = 0; i < 6; i++) begin
      act_in <= 6'(1 << i);
      @(posedge pclk);
      act_in <= 6'h00;
      repeat (3) @(posedge pclk);
      apb(1'b0, OFF_STATUS, 32'h0); chk(q, 32'h80 | (32'h1 << i));
      repeat (25) @(posedge pclk);
      apb(1'b0, OFF_STATUS, 32'h0); chk(q, 32'h0000_0080);
    end
  endtask : t_act

  task automatic t_tx();
    pulse(4'h2);
    apb(1'b0, OFF_STATUS, 32'h0); chk(q, 32'h0000_0000);
    pulse(4'h1);
    apb(1'b0, OFF_STATUS, 32'h0); chk(q, 32'h0000_00C0);
    pulse(4'h2);
    pulse(4'h2);
    pulse(4'h1);
    apb(1'b0, OFF_STATUS, 32'h0); chk(q, 32'h0000_0000);
    pulse(4'h1);
    apb(1'b0, OFF_STATUS, 32'h0); chk(q, 32'h0000_00C0);
  endtask : t_tx

  // ==========================================================
  // Clock, timeout and main sequence
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ctl = 4'h0;
    act_in = 6'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_regs();
    t_rst_mid();
    t_rx();
    t_act();
    t_tx();
    t_tick();
    summarize();
  end
endmodule : i2csd_regs_bench

`default_nettype wire
